// file: tap_abort_policy.v
// How it works
// - state commits only on clean region end; aborted updates are discarded.
// - explicit abort, id query, spin hint, enclave leaves always abort.
// - direction flag set/clear aborts only when the flag value changes.
// - pointer, general and status flag work never aborts; vector register work aborts only on a narrow/wide mix.
// - mixing narrow and wide vector instructions may abort, when enabled.
// - implementation-dependent instructions abort only when the policy input enables it.
// - fences, timestamp reads and other unlisted instructions do not abort.
// - transactional instructions accepted at every privilege level; no privilege check.
// - faults, traps, unmasked exceptions in a region are suppressed and abort.
// - would-be virtual machine exit in guest mode aborts instead.
// - synchronous and guest synchronous events suppressed and abort; replay delivers them.
// - asynchronous events abort, are held pending, delivered after rollback.
// - non write-back access or uncached fetch aborts the region.
// - accessed/dirty updates abort if enabled; page walks on own writes abort.
// - on abort the translation caches are squashed of uncommitted writes.
// - detected self or cross modifying code aborts the region.
// - tracking set exhaustion aborts; no capacity is promised.
// - remote write to read line, or remote access to written line, conflicts.
// - coherence traffic flagged as false conflict also aborts.
// - conflict aborts set status bit 2.
// - tracking overflow aborts set status bit 3.
// - explicit abort sets bit 0, argument in 31:24, retry bit clear.
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_abort_policy (
  input  wire                       CLK,
  input  wire                       RESET,
  input  wire                       TXN_BEGIN,
  input  wire                       TXN_END,
  input  wire                       ROLLBACK_DONE,
  input  wire                       INSTR_VALID,
  input  wire [`TAP_CLS_W-1:0]      INSTR_CLASS,
  input  wire [`TAP_ARG_W-1:0]      INSTR_ARG,
  input  wire                       DIRECTION_FLAG,
  input  wire                       GUEST_MODE,
  input  wire                       WOULD_VM_EXIT,
  input  wire                       IMPL_ABORT_EN,
  input  wire                       VEC_MIX_ABORT_EN,
  input  wire                       AD_UPDATE_ABORT_EN,
  input  wire                       SYNC_EXC,
  input  wire                       SYNC_EXC_DEBUG,
  input  wire                       GUEST_SYNC_EVT,
  input  wire [`TAP_EVT_W-1:0]      ASYNC_EVT,
  input  wire                       MEM_VALID,
  input  wire                       MEM_WRITE,
  input  wire                       MEM_WB,
  input  wire [`TAP_LINE_W-1:0]     MEM_LINE,
  input  wire                       FETCH_UC,
  input  wire                       AD_UPDATE_NEEDED,
  input  wire                       WALK_HITS_OWN,
  input  wire                       SMC_DETECT,
  input  wire                       SNOOP_VALID,
  input  wire                       SNOOP_WRITE,
  input  wire [`TAP_LINE_W-1:0]     SNOOP_LINE,
  input  wire                       FALSE_CONFLICT,
  output reg                        IN_REGION,
  output reg                        ABORT_REQ,
  output reg  [`TAP_ST_W-1:0]       ABORT_STATUS,
  output reg                        COMMIT_OK,
  output reg                        TLB_SQUASH,
  output reg                        SUPPRESS_EXC,
  output reg                        AD_VISIBLE,
  output reg  [`TAP_EVT_W-1:0]      EVT_PENDING,
  output reg  [`TAP_EVT_W-1:0]      EVT_DELIVER
);

  localparam [`TAP_STATE_W-1:0] ST_IDLE     = 2'h0;
  localparam [`TAP_STATE_W-1:0] ST_ACTIVE   = 2'h1;
  localparam [`TAP_STATE_W-1:0] ST_ABORTING = 2'h2;

  reg  [`TAP_STATE_W-1:0]  state;
  reg  [`TAP_STATE_W-1:0]  next_state;
  reg                      used_narrow;
  reg                      used_wide;
  reg                      cause_explicit;
  reg                      cause_always;
  reg                      cause_dir;
  reg                      cause_vec;
  reg                      cause_impl;
  reg                      cause_vmexit;
  reg                      cause_sync;
  reg                      cause_async;
  reg                      cause_mem;
  reg                      cause_walk;
  reg                      cause_smc;
  reg                      cause_conf;
  reg                      cause_ovf;
  reg                      any_cause;
  reg  [`TAP_ST_W-1:0]     next_status;
  wire                     active;
  wire                     trk_conflict;
  wire                     trk_overflow;
  wire                     trk_clear;
  wire                     trk_acc;

  assign active    = (state == ST_ACTIVE);
  // the set restarts empty with every region
  assign trk_clear = (state == ST_IDLE) && TXN_BEGIN;
  // only write-back traffic is tracked; anything else aborts instead
  assign trk_acc   = active && MEM_VALID && MEM_WB;

  tap_track_set u_track (
    .clk       (CLK),
    .reset     (RESET),
    .clear     (trk_clear),
    .acc_valid (trk_acc),
    .acc_write (MEM_WRITE),
    .acc_addr  (MEM_LINE),
    .snp_valid (SNOOP_VALID),
    .snp_write (SNOOP_WRITE),
    .snp_addr  (SNOOP_LINE),
    .conflict  (trk_conflict),
    .overflow  (trk_overflow)
  );

  // instruction causes; they count only while the region is active
  always @* begin
    cause_explicit = 1'b0;
    cause_always   = 1'b0;
    cause_dir      = 1'b0;
    cause_vec      = 1'b0;
    cause_impl     = 1'b0;
    cause_vmexit   = 1'b0;
    if (active && INSTR_VALID) begin
      case (INSTR_CLASS)
        `TAP_CLS_EXPLICIT_ABORT: begin
          cause_explicit = 1'b1;
        end
        `TAP_CLS_ID_QUERY, `TAP_CLS_SPIN_HINT,
        `TAP_CLS_ENCL_SUP, `TAP_CLS_ENCL_USER: begin
          cause_always = 1'b1;
        end
        `TAP_CLS_CLEAR_DIR: begin
          // a no-change write of the flag is harmless
          cause_dir = DIRECTION_FLAG;
        end
        `TAP_CLS_SET_DIR: begin
          cause_dir = !DIRECTION_FLAG;
        end
        `TAP_CLS_NARROW_VEC: begin
          cause_vec = VEC_MIX_ABORT_EN && used_wide;
        end
        `TAP_CLS_WIDE_VEC: begin
          cause_vec = VEC_MIX_ABORT_EN && used_narrow;
        end
        `TAP_CLS_IMPL_DEP: begin
          // off by default: software must not lean on these to abort
          cause_impl = IMPL_ABORT_EN;
        end
        default: begin
          // plain, fence/timestamp and transactional classes raise no cause
          cause_impl = 1'b0;
        end
      endcase
      cause_vmexit = GUEST_MODE && WOULD_VM_EXIT;
    end
  end

  // event causes; they too count only while the region is active
  always @* begin
    cause_sync  = 1'b0;
    cause_async = 1'b0;
    cause_mem   = 1'b0;
    cause_walk  = 1'b0;
    cause_smc   = 1'b0;
    cause_conf  = 1'b0;
    cause_ovf   = 1'b0;
    if (active) begin
      cause_sync  = SYNC_EXC || (GUEST_MODE && GUEST_SYNC_EVT);
      cause_async = |ASYNC_EVT;
      cause_mem   = (MEM_VALID && !MEM_WB) || FETCH_UC;
      cause_walk  = (AD_UPDATE_NEEDED && AD_UPDATE_ABORT_EN) ||
                    WALK_HITS_OWN;
      cause_smc   = SMC_DETECT;
      cause_conf  = trk_conflict || FALSE_CONFLICT;
      cause_ovf   = trk_overflow;
    end
    any_cause = cause_explicit || cause_always || cause_dir || cause_vec ||
                cause_impl || cause_vmexit || cause_sync || cause_async ||
                cause_mem || cause_walk || cause_smc || cause_conf || cause_ovf;
  end

  // status word; many causes may be reported together
  // nesting is not tracked, so no nested-abort cause is ever reported
  always @* begin
    next_status = `TAP_ST_RESET;
    next_status[`TAP_ST_EXPLICIT] = cause_explicit;
    next_status[`TAP_ST_CONFLICT] = cause_conf;
    next_status[`TAP_ST_OVERFLOW] = cause_ovf;
    next_status[`TAP_ST_DEBUG]    = cause_sync && SYNC_EXC && SYNC_EXC_DEBUG;
    // transient causes may succeed on retry, never alongside an explicit abort
    next_status[`TAP_ST_RETRY]    = !cause_explicit && (cause_conf || cause_async);
    if (cause_explicit) begin
      next_status[`TAP_ST_ARG_HI:`TAP_ST_ARG_LO] = INSTR_ARG;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // no privilege input exists, so every level may open a region
        if (TXN_BEGIN) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // an abort cause in the same cycle as region end beats the commit
        if (any_cause) begin
          next_state = ST_ABORTING;
        end else if (TXN_END) begin
          next_state = ST_IDLE;
        end
      end
      ST_ABORTING: begin
        if (ROLLBACK_DONE) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // region sequencing
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state     <= ST_IDLE;
      IN_REGION <= 1'b0;
    end else begin
      state     <= next_state;
      IN_REGION <= (next_state != ST_IDLE);
    end
  end

  // only one request per region: later causes are not looked at while aborting
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ABORT_REQ  <= 1'b0;
      TLB_SQUASH <= 1'b0;
      COMMIT_OK  <= 1'b0;
    end else begin
      ABORT_REQ  <= active && any_cause;
      TLB_SQUASH <= active && any_cause;
      COMMIT_OK  <= active && !any_cause && TXN_END;
    end
  end

  // the status stays readable until the next region starts
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ABORT_STATUS <= `TAP_ST_RESET;
    end else if (active && any_cause) begin
      ABORT_STATUS <= next_status;
    end else if (trk_clear) begin
      ABORT_STATUS <= `TAP_ST_RESET;
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SUPPRESS_EXC <= 1'b0;
      AD_VISIBLE   <= 1'b0;
    end else begin
      // exceptions anywhere inside the region never reach software from here
      SUPPRESS_EXC <= (state != ST_IDLE) &&
                      (SYNC_EXC || (GUEST_MODE && GUEST_SYNC_EVT));
      // flag updates leak out only when the policy does not abort on them
      AD_VISIBLE <= active && AD_UPDATE_NEEDED && !AD_UPDATE_ABORT_EN;
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      used_narrow <= 1'b0;
      used_wide   <= 1'b0;
    end else if (trk_clear) begin
      used_narrow <= 1'b0;
      used_wide   <= 1'b0;
    end else if (active && INSTR_VALID) begin
      // vector work itself is fine; only the mix is remembered
      used_narrow <= used_narrow || (INSTR_CLASS == `TAP_CLS_NARROW_VEC);
      used_wide   <= used_wide || (INSTR_CLASS == `TAP_CLS_WIDE_VEC);
    end
  end

  // events pend while a region or its rollback is in flight
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      EVT_PENDING <= `TAP_EVT_NONE;
      EVT_DELIVER <= `TAP_EVT_NONE;
    end else if (state == ST_IDLE) begin
      EVT_DELIVER <= EVT_PENDING | ASYNC_EVT;
      EVT_PENDING <= `TAP_EVT_NONE;
    end else begin
      EVT_DELIVER <= `TAP_EVT_NONE;
      // new arrivals are or-ed in, so none is lost while the region unwinds
      EVT_PENDING <= EVT_PENDING | ASYNC_EVT;
    end
  end

endmodule // tap_abort_policy

// file: tap_consts.vh
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// retired instruction classes, as presented by decode on INSTR_CLASS
`define TAP_CLS_W              4
`define TAP_CLS_PLAIN          4'h0
`define TAP_CLS_EXPLICIT_ABORT 4'h1
`define TAP_CLS_ID_QUERY       4'h2
`define TAP_CLS_SPIN_HINT      4'h3
`define TAP_CLS_ENCL_SUP       4'h4
`define TAP_CLS_ENCL_USER      4'h5
`define TAP_CLS_CLEAR_DIR      4'h6
`define TAP_CLS_SET_DIR        4'h7
`define TAP_CLS_NARROW_VEC     4'h8
`define TAP_CLS_WIDE_VEC       4'h9
`define TAP_CLS_IMPL_DEP       4'hA
`define TAP_CLS_FENCE_TS       4'hB
`define TAP_CLS_TXN_INSTR      4'hC

// abort status word layout (accumulator_register image)
`define TAP_ST_W               32
`define TAP_ST_RESET           32'h0000_0000
`define TAP_ST_EXPLICIT        0
`define TAP_ST_RETRY           1
`define TAP_ST_CONFLICT        2
`define TAP_ST_OVERFLOW        3
`define TAP_ST_DEBUG           4
`define TAP_ST_ARG_HI          31
`define TAP_ST_ARG_LO          24
`define TAP_ARG_W              8

// asynchronous event lines
`define TAP_EVT_W              5
`define TAP_EVT_NONE           5'h00

// tracking set geometry
`define TAP_LINE_W             26
`define TAP_TRK_DEPTH          8
`define TAP_TRK_IDX_W          3

// region states
`define TAP_STATE_W            2

`endif

// file: tap_track_set.v
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_track_set (
  input  wire                       clk,
  input  wire                       reset,
  input  wire                       clear,
  input  wire                       acc_valid,
  input  wire                       acc_write,
  input  wire [`TAP_LINE_W-1:0]     acc_addr,
  input  wire                       snp_valid,
  input  wire                       snp_write,
  input  wire [`TAP_LINE_W-1:0]     snp_addr,
  output reg                        conflict,
  output reg                        overflow
);

  reg  [`TAP_TRK_DEPTH-1:0]  vld;
  reg  [`TAP_TRK_DEPTH-1:0]  wr;
  reg  [`TAP_LINE_W-1:0]     tag [0:`TAP_TRK_DEPTH-1];
  reg                        acc_hit;
  reg  [`TAP_TRK_IDX_W-1:0]  acc_idx;
  reg                        free_found;
  reg  [`TAP_TRK_IDX_W-1:0]  free_idx;
  reg                        snp_hit;
  integer                    i;
  integer                    j;

  always @* begin
    acc_hit    = 1'b0;
    acc_idx    = {`TAP_TRK_IDX_W{1'b0}};
    free_found = 1'b0;
    free_idx   = {`TAP_TRK_IDX_W{1'b0}};
    snp_hit    = 1'b0;
    for (i = 0; i < `TAP_TRK_DEPTH; i = i + 1) begin
      if (vld[i] && (tag[i] == acc_addr)) begin
        acc_hit = 1'b1;
        acc_idx = i[`TAP_TRK_IDX_W-1:0];
      end
      if (!vld[i] && !free_found) begin
        free_found = 1'b1;
        free_idx   = i[`TAP_TRK_IDX_W-1:0];
      end
      // remote write hits a read or written line; remote read hits a written line
      if (vld[i] && (tag[i] == snp_addr) && (snp_write || wr[i])) begin
        snp_hit = 1'b1;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      vld      <= {`TAP_TRK_DEPTH{1'b0}};
      wr       <= {`TAP_TRK_DEPTH{1'b0}};
      conflict <= 1'b0;
      overflow <= 1'b0;
      for (j = 0; j < `TAP_TRK_DEPTH; j = j + 1) begin
        tag[j] <= {`TAP_LINE_W{1'b0}};
      end
    end else if (clear) begin
      vld      <= {`TAP_TRK_DEPTH{1'b0}};
      wr       <= {`TAP_TRK_DEPTH{1'b0}};
      conflict <= 1'b0;
      overflow <= 1'b0;
    end else begin
      conflict <= snp_valid && snp_hit;
      // no spare entry: the region cannot be tracked any further
      overflow <= acc_valid && !acc_hit && !free_found;
      if (acc_valid) begin
        if (acc_hit) begin
          wr[acc_idx] <= wr[acc_idx] | acc_write;
        end else if (free_found) begin
          vld[free_idx] <= 1'b1;
          wr[free_idx]  <= acc_write;
          tag[free_idx] <= acc_addr;
        end
      end
    end
  end

endmodule // tap_track_set

// file: tap_abort_props.sv
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_abort_props (
  input wire                   CLK,
  input wire                   RESET,
  input wire                   TXN_END,
  input wire                   INSTR_VALID,
  input wire [`TAP_CLS_W-1:0]  INSTR_CLASS,
  input wire [`TAP_ARG_W-1:0]  INSTR_ARG,
  input wire                   DIRECTION_FLAG,
  input wire                   SYNC_EXC,
  input wire                   SYNC_EXC_DEBUG,
  input wire [`TAP_EVT_W-1:0]  ASYNC_EVT,
  input wire                   MEM_VALID,
  input wire                   MEM_WRITE,
  input wire                   MEM_WB,
  input wire [`TAP_LINE_W-1:0] MEM_LINE,
  input wire                   SNOOP_VALID,
  input wire                   SNOOP_WRITE,
  input wire [`TAP_LINE_W-1:0] SNOOP_LINE,
  input wire                   IN_REGION,
  input wire                   ABORT_REQ,
  input wire [`TAP_ST_W-1:0]   ABORT_STATUS,
  input wire                   COMMIT_OK,
  input wire                   TLB_SQUASH,
  input wire [`TAP_EVT_W-1:0]  EVT_PENDING,
  input wire [`TAP_EVT_W-1:0]  EVT_DELIVER
);
  reg  ab;
  wire act;
  // ab remembers that this region already asked for its abort
  always @(posedge CLK or posedge RESET) begin
    if (RESET) ab <= 1'b0;
    else if (!IN_REGION) ab <= 1'b0;
    else if (ABORT_REQ) ab <= 1'b1;
  end
  assign act = IN_REGION && !ab && !ABORT_REQ;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_rd;
    act && MEM_VALID && MEM_WB && !MEM_WRITE && !TXN_END;
  endsequence
  sequence s_wr_hit;
    act && SNOOP_VALID && SNOOP_WRITE && SNOOP_LINE == $past(MEM_LINE) && !TXN_END;
  endsequence
  a_explicit_status: assert property (act && INSTR_VALID && INSTR_CLASS == `TAP_CLS_EXPLICIT_ABORT
    |=> ABORT_REQ && ABORT_STATUS[0] && !ABORT_STATUS[1] && ABORT_STATUS[31:24] == $past(INSTR_ARG))
    else $error("explicit abort status wrong");
  a_always_abort: assert property (act && INSTR_VALID
    && INSTR_CLASS inside {[`TAP_CLS_EXPLICIT_ABORT:`TAP_CLS_ENCL_USER]} |=> ABORT_REQ)
    else $error("always-abort class did not abort");
  a_dir_change: assert property (act && INSTR_VALID
    && ((INSTR_CLASS == `TAP_CLS_CLEAR_DIR && DIRECTION_FLAG)
    || (INSTR_CLASS == `TAP_CLS_SET_DIR && !DIRECTION_FLAG)) |=> ABORT_REQ)
    else $error("direction change did not abort");
  a_single_req: assert property (ab |-> !ABORT_REQ)
    else $error("second abort request in one region");
  a_squash_pair: assert property (TLB_SQUASH == ABORT_REQ)
    else $error("squash not paired with abort");
  a_commit_clean: assert property (COMMIT_OK |-> !ab && $past(TXN_END))
    else $error("commit after abort or without end");
  a_conflict_bits: assert property (s_rd ##1 s_wr_hit ##1 (act && !TXN_END)
    |=> ABORT_REQ && ABORT_STATUS[2])
    else $error("conflict abort missing");
  a_evt_pend: assert property (act && ASYNC_EVT != 0 |=> ABORT_REQ && ABORT_STATUS[1]
    && (EVT_PENDING & $past(ASYNC_EVT)) == $past(ASYNC_EVT))
    else $error("async event not pended");
  a_evt_held: assert property (IN_REGION && $past(IN_REGION) |-> EVT_DELIVER == 0)
    else $error("event delivered inside region");
  a_fault_abort: assert property (act && SYNC_EXC
    |=> ABORT_REQ && ABORT_STATUS[4] == $past(SYNC_EXC_DEBUG))
    else $error("fault not turned into abort");
endmodule // tap_abort_props
bind tap_abort_policy tap_abort_props tap_abort_props_i (.CLK(CLK), .RESET(RESET),
  .TXN_END(TXN_END), .INSTR_VALID(INSTR_VALID), .INSTR_CLASS(INSTR_CLASS),
  .INSTR_ARG(INSTR_ARG), .DIRECTION_FLAG(DIRECTION_FLAG), .SYNC_EXC(SYNC_EXC),
  .SYNC_EXC_DEBUG(SYNC_EXC_DEBUG), .ASYNC_EVT(ASYNC_EVT), .MEM_VALID(MEM_VALID),
  .MEM_WRITE(MEM_WRITE), .MEM_WB(MEM_WB), .MEM_LINE(MEM_LINE), .SNOOP_VALID(SNOOP_VALID),
  .SNOOP_WRITE(SNOOP_WRITE), .SNOOP_LINE(SNOOP_LINE), .IN_REGION(IN_REGION),
  .ABORT_REQ(ABORT_REQ), .ABORT_STATUS(ABORT_STATUS), .COMMIT_OK(COMMIT_OK),
  .TLB_SQUASH(TLB_SQUASH), .EVT_PENDING(EVT_PENDING), .EVT_DELIVER(EVT_DELIVER));

// file: tap_peer_cpu.sv
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_peer_cpu (
  input  wire                   clk,
  input  wire                   go,
  input  wire                   wr,
  input  wire [`TAP_LINE_W-1:0] line,
  output reg                    snoop_valid,
  output reg                    snoop_write,
  output reg  [`TAP_LINE_W-1:0] snoop_line
);
  initial begin
    snoop_valid = 1'b0;
    snoop_write = 1'b0;
    snoop_line = 26'h000_0000;
  end
  // outside a request snoop_valid stays low while the write qualifier and line keep toggling, so a stale line never passes as valid
  always @(posedge clk) begin
    snoop_valid <= go;
    snoop_write <= go ? wr : ~snoop_write;
    snoop_line <= go ? line : ~snoop_line;
  end
endmodule // tap_peer_cpu

// file: test_tap_abort_policy.sv
`timescale 1ns/1ps
`include "tap_consts.vh"
module test_tap_abort_policy;
  reg         CLK = 1'b0;
  reg         RESET = 1'b1;
  reg  [15:0] pl = 16'h0000;
  reg  [15:0] next_pl = 16'h0000;
  reg  [4:0]  lv = 5'h00;
  reg  [4:0]  next_lv = 5'h00;
  reg  [3:0]  cls = 4'h0;
  reg  [3:0]  next_cls = 4'h0;
  reg  [7:0]  arg = 8'h00;
  reg  [7:0]  next_arg = 8'h00;
  reg  [4:0]  aev = 5'h00;
  reg  [4:0]  next_aev = 5'h00;
  reg  [25:0] mln = 26'h000_0000;
  reg  [25:0] next_mln = 26'h000_0000;
  reg  [1:0]  pg = 2'b00;
  reg  [1:0]  next_pg = 2'b00;
  wire        snv, snw, in_r, ab_req, cok, sq, sup, adv;
  wire [25:0] snl;
  wire [31:0] st;
  wire [4:0]  evp, evd;
  integer     seed, n_mismatch, checked, k, i;
  reg  [31:0] r;
  reg  [4:0]  ev;
  always #20 CLK = ~CLK;
  tap_peer_cpu tap_peer_cpu_i (.clk(CLK), .go(pg[1]), .wr(pg[0]), .line(mln),
    .snoop_valid(snv), .snoop_write(snw), .snoop_line(snl));
  tap_abort_policy tap_abort_policy_i (
    .CLK(CLK), .RESET(RESET), .TXN_BEGIN(pl[0]), .TXN_END(pl[1]), .ROLLBACK_DONE(pl[2]),
    .INSTR_VALID(pl[3]), .INSTR_CLASS(cls), .INSTR_ARG(arg), .DIRECTION_FLAG(lv[0]),
    .GUEST_MODE(lv[1]), .WOULD_VM_EXIT(pl[4]), .IMPL_ABORT_EN(lv[2]), .VEC_MIX_ABORT_EN(lv[3]),
    .AD_UPDATE_ABORT_EN(lv[4]), .SYNC_EXC(pl[5]), .SYNC_EXC_DEBUG(pl[6]), .GUEST_SYNC_EVT(pl[7]),
    .ASYNC_EVT(aev), .MEM_VALID(pl[8]), .MEM_WRITE(pl[9]), .MEM_WB(pl[10]), .MEM_LINE(mln),
    .FETCH_UC(pl[11]), .AD_UPDATE_NEEDED(pl[12]), .WALK_HITS_OWN(pl[13]), .SMC_DETECT(pl[14]),
    .SNOOP_VALID(snv), .SNOOP_WRITE(snw), .SNOOP_LINE(snl), .FALSE_CONFLICT(pl[15]),
    .IN_REGION(in_r), .ABORT_REQ(ab_req), .ABORT_STATUS(st), .COMMIT_OK(cok), .TLB_SQUASH(sq),
    .SUPPRESS_EXC(sup), .AD_VISIBLE(adv), .EVT_PENDING(evp), .EVT_DELIVER(evd));
  function [19:0] stim(input [4:0] c);
    case (c)
      5'd0, 5'd1, 5'd2, 5'd3, 5'd4: stim = {c[3:0] + 4'h1, 16'h0008};
      5'd5: stim = {`TAP_CLS_CLEAR_DIR, 16'h0008};
      5'd6: stim = {`TAP_CLS_SET_DIR, 16'h0008};
      5'd7: stim = 20'h0_0020;
      5'd8: stim = 20'h0_0060;
      5'd9: stim = {`TAP_CLS_PLAIN, 16'h0018};
      5'd10: stim = 20'h0_0080;
      5'd11: stim = 20'h0_0800;
      5'd12: stim = 20'h0_0100;
      5'd13: stim = 20'h0_2000;
      5'd14: stim = 20'h0_4000;
      5'd15: stim = 20'h0_8000;
      5'd16: stim = {`TAP_CLS_IMPL_DEP, 16'h0008};
      5'd17: stim = 20'h0_1000;
      5'd18: stim = {`TAP_CLS_WIDE_VEC, 16'h0008};
      default: stim = 20'h0_0000;
    endcase
  endfunction
  function [4:0] lvl(input [4:0] c);
    lvl = {c == 5'd17, c == 5'd18, c == 5'd16, c == 5'd9 || c == 5'd10, c == 5'd5};
  endfunction
  function [31:0] want(input [4:0] c, input [7:0] a);
    if (c == 5'd0) want = {a, 24'h00_0001};
    else if (c == 5'd8) want = 32'h0000_0010;
    else if (c == 5'd15 || c == 5'd19) want = 32'h0000_0002;
    else want = 32'h0000_0000;
  endfunction
  task tick;
    begin
      @(posedge CLK);
      pl <= next_pl;
      lv <= next_lv;
      cls <= next_cls;
      arg <= next_arg;
      aev <= next_aev;
      mln <= next_mln;
      pg <= next_pg;
      next_pl = 16'h0000;
      next_aev = 5'h00;
      next_pg = 2'b00;
      #1;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task open_rgn(input [4:0] l);
    begin
      next_lv = l;
      next_pl[0] = 1'b1;
      tick;
      tick;
      check(in_r, 1);
    end
  endtask
  // a late fault while rolling back must be swallowed without a second request
  task close_abort(input [31:0] w, input [31:0] m);
    begin
      check(ab_req, 1);
      check(sq, 1);
      check(st & m, w);
      next_pl[5] = 1'b1;
      tick;
      check(ab_req, 0);
      next_pl[2] = 1'b1;
      tick;
      check({sup, ab_req}, 2'b10);
      tick;
      check({in_r, cok}, 2'b00);
    end
  endtask
  initial begin
    #(5000 * 40);
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial begin
    seed = 94399;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    check({in_r, ab_req, cok, sq, sup, adv, evp, evd}, 0);
    check(st, `TAP_ST_RESET);
    {next_cls, next_pl} = 20'h1_4008;
    tick;
    tick;
    check(ab_req, 0);
    open_rgn(5'h00);
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      next_cls = (r[3:0] > 4'hC || (r[3:0] > 4'h0 && r[3:0] < 4'h6)) ? 4'hB : r[3:0];
      next_lv = {4'h0, next_cls == `TAP_CLS_SET_DIR};
      next_pl = {5'h00, 1'b1, r[9], r[10], 4'h0, r[8], 3'b000};
      next_mln = {24'h00_0000, r[12:11]};
      tick;
      check(ab_req, 0);
    end
    next_pl[12] = 1'b1;
    tick;
    tick;
    check(adv, 1);
    next_pl[1] = 1'b1;
    tick;
    tick;
    check({cok, in_r, ab_req}, 3'b100);
    open_rgn(5'h00);
    next_pl = 16'h4002;
    tick;
    tick;
    close_abort(32'h0000_0000, 32'hFF00_001B);
    for (k = 0; k < 20; k = k + 1) begin
      open_rgn(lvl(k[4:0]));
      if (k == 18) begin
        next_pl[3] = 1'b1;
        next_cls = `TAP_CLS_NARROW_VEC;
        tick;
      end
      r = $random(seed);
      ev = r[4:0] | 5'h01;
      {next_cls, next_pl} = stim(k[4:0]);
      next_arg = r[15:8];
      if (k == 19) next_aev = ev;
      tick;
      tick;
      if (k == 7 || k == 8) check(sup, 1);
      if (k == 19) check(evp, ev);
      close_abort(want(k[4:0], arg), 32'hFF00_001B);
      if (k == 19) begin
        tick;
        check({evd, evp}, {ev, 5'h00});
      end
    end
    for (i = 0; i < 2; i = i + 1) begin
      open_rgn(5'h00);
      r = $random(seed);
      next_pl = (i == 1) ? 16'h0700 : 16'h0500;
      next_pg = {1'b1, i == 0};
      next_mln = r[25:0];
      tick;
      repeat (3) tick;
      close_abort(32'h0000_0006, 32'hFFFF_FFFF);
    end
    open_rgn(5'h00);
    r = $random(seed);
    for (i = 0; i < 9; i = i + 1) begin
      next_pl = 16'h0700;
      next_mln = r[25:0] + i[25:0];
      tick;
    end
    repeat (2) tick;
    close_abort(32'h0000_0008, 32'hFFFF_FFFF);
    end_of_test;
  end
endmodule // test_tap_abort_policy
